// ===== inc/spi_chain_pkg.sv
// Shared constants and types for the daisy-chain serial control port
package spi_chain_pkg;

  // Timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int SCLK_PERIOD_PS = 125000;
  // Half serial period rounded down, never below one cycle
  localparam int SCLK_HALF_RAW = (SCLK_PERIOD_PS / 2) / CLK_PERIOD_PS;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_RAW < 1) ? 1 : SCLK_HALF_RAW;

  // Framing
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int ADDR_USED_W = 6;
  localparam int CID_W = 4;
  localparam int CHAIN_MAX = 16;
  localparam logic [1:0] FRAMES_NARROW = 2'h3;
  localparam logic [1:0] FRAMES_WIDE = 2'h2;
  localparam logic [4:0] DATA_BIT_IDX = 5'h10;

  // Control byte layout
  localparam int BIT_BCAST = 7;
  localparam int BIT_READ = 6;
  localparam int BIT_ONE = 5;
  localparam int BIT_ZERO = 4;
  localparam logic [2:0] CID_FIRST_IDX = 3'h4;

  // Controller registers on APB
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam int CMD_CID_LSB = 0;
  localparam int CMD_READ_BIT = 4;
  localparam int CMD_BCAST_BIT = 5;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_DATA_LSB = 16;
  localparam int CMD_WIDE_BIT = 24;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_RDATA_LSB = 8;

  typedef enum logic [1:0] {
    DEV_CTRL, DEV_ADDR, DEV_DATA, DEV_TAIL
  } dev_state_t;

  typedef enum logic [2:0] {
    H_IDLE, H_LEAD, H_LOW, H_HIGH, H_GAP
  } host_state_t;

endpackage : spi_chain_pkg

// ===== inc/spi_chain_if.sv
// Link wires between the serial controller and one chained device
`timescale 1ns/1ps
interface spi_chain_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic mosi_oe;
  logic sdo;
  logic sdo_oe;
  logic serial_pass_through_out;
  logic miso;

  // Return line is pulled high while no device drives it
  assign miso = sdo_oe ? sdo : 1'b1;

  modport host (
    output sclk, cs_n, mosi, mosi_oe,
    input miso
  );

  modport dev (
    input sclk, cs_n, mosi,
    output sdo, sdo_oe, serial_pass_through_out
  );
endinterface : spi_chain_if

// ===== hw/spi_chain_sync.sv
// Two-stage synchroniser with edge pulses for idle-high link lines
`timescale 1ns/1ps
module spi_chain_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] lvl_o,
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '1;
      sync_q <= '1;
      prev_q <= '1;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign lvl_o = sync_q;
  assign rise_o = sync_q & ~prev_q;
  assign fall_o = ~sync_q & prev_q;
endmodule : spi_chain_sync

// ===== hw/spi_chain_device.sv
// Daisy-chain serial control port, device end
//
// Behaviour
// - Up to sixteen devices chained via pass-through
// - Control, address, data bytes; six address bits
// - Every byte shifted most significant bit first
// - Free clock: select frames each whole byte
// - Gated clock: eight cycles, idles high
// - Wired lines: controller releases during read data
// - Select change mid-byte returns to idle
// - Broadcast used by controller for writes only
// - Control bit six: one read, zero write
// - Control bits five, four sent one, zero
// - Channel field sent least significant first
// - Forward channel minus one; zero executes
// - Broadcast forwards channel unchanged, all apply
// - Broadcast and direction bits forwarded unchanged
// - Narrow controller: three framed byte transfers
// - Select toggle after data ends single byte
// - Serial input ignored during read data
// - Wide controller: select low means eight more
// - Wide write discards the last eight bits
// - Wide read repeats the register value
// - Narrow or wide framing detected automatically
`timescale 1ns/1ps
module spi_chain_device (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  spi_chain_if.dev LINK,
  output logic [spi_chain_pkg::ADDR_USED_W-1:0] REG_ADDR_O,
  output logic [spi_chain_pkg::BYTE_W-1:0] REG_WDATA_O,
  output logic REG_WR_O,
  output logic REG_RD_O,
  input wire logic [spi_chain_pkg::BYTE_W-1:0] REG_RDATA_I,
  output logic BCAST_O
);

  ////////////////////////////////////////////////////////////////////////
  // Pin capture

  logic [2:0] pin_lvl;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;

  spi_chain_sync #(
    .W(3)
  ) u_sync (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .d_i({LINK.sclk, LINK.cs_n, LINK.mosi}),
    .lvl_o(pin_lvl),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  wire sclk_rise = pin_rise[2];
  wire sclk_fall = pin_fall[2];
  wire cs_n_s = pin_lvl[1];
  wire cs_rise = pin_rise[1];
  wire cs_edge = pin_rise[1] | pin_fall[1];
  wire sdi_s = pin_lvl[0];

  ////////////////////////////////////////////////////////////////////////
  // State

  spi_chain_pkg::dev_state_t state_q;
  spi_chain_pkg::dev_state_t state_d;
  logic [2:0] bit_q;
  logic [spi_chain_pkg::BYTE_W-1:0] shift_q;
  logic [spi_chain_pkg::BYTE_W-1:0] out_q;
  logic [spi_chain_pkg::ADDR_USED_W-1:0] addr_q;
  logic [spi_chain_pkg::BYTE_W-1:0] wdata_q;
  logic bcast_q;
  logic read_q;
  logic target_q;
  logic borrow_q;
  logic fwd_q;
  logic thru_q;
  logic sdo_q;
  logic oe_q;
  logic wr_q;
  logic rd_q;
  logic rd_pend_q;

  ////////////////////////////////////////////////////////////////////////
  // Decode

  wire take = sclk_rise & ~cs_n_s;
  wire drive = sclk_fall & ~cs_n_s;
  wire at_boundary = (bit_q == 3'h0);
  wire resync = cs_edge & ~at_boundary;
  wire byte_done = take & (bit_q == 3'h7);
  wire [spi_chain_pkg::BYTE_W-1:0] byte_in = {shift_q[6:0], sdi_s};
  wire in_ctrl = (state_q == spi_chain_pkg::DEV_CTRL);
  wire first_bit = in_ctrl & at_boundary;
  wire in_cid = in_ctrl & (bit_q >= spi_chain_pkg::CID_FIRST_IDX);

  // Serial decrement rides the least significant bit first order
  wire dec_bit = sdi_s ^ borrow_q;
  wire fwd_bit = (in_cid & ~bcast_q) ? dec_bit : sdi_s;
  // Borrow only ripples through the channel bits, never bits 6 to 4
  wire borrow_d = first_bit ? 1'b1 :
                  (in_cid ? (borrow_q & ~sdi_s) : borrow_q);

  // Channel field arrives as bits 3 down to 0 = ids 0 up to 3
  wire cid_zero = (byte_in[spi_chain_pkg::CID_W-1:0] == 4'h0);
  wire ctrl_target = byte_in[spi_chain_pkg::BIT_BCAST] | cid_zero;
  wire ctrl_read = byte_in[spi_chain_pkg::BIT_READ];

  // Broadcast reads are never answered to avoid line contention
  wire answer = read_q & target_q & ~bcast_q;
  wire ctrl_read_q_ok = read_q & target_q & ~bcast_q;
  wire data_phase = (state_q == spi_chain_pkg::DEV_DATA) ||
                    (state_q == spi_chain_pkg::DEV_TAIL);
  wire do_write = byte_done & (state_q == spi_chain_pkg::DEV_DATA) &
                  ~read_q & target_q;
  wire do_read = byte_done & (state_q == spi_chain_pkg::DEV_ADDR) &
                 ctrl_read_q_ok;
  wire tail_end = cs_rise & (state_q == spi_chain_pkg::DEV_TAIL);

  ////////////////////////////////////////////////////////////////////////
  // Byte sequencer

  always_comb begin
    state_d = state_q;
    if (resync || tail_end) begin
      state_d = spi_chain_pkg::DEV_CTRL;
    end else if (byte_done) begin
      unique case (state_q)
        spi_chain_pkg::DEV_CTRL: state_d = spi_chain_pkg::DEV_ADDR;
        spi_chain_pkg::DEV_ADDR: state_d = spi_chain_pkg::DEV_DATA;
        // Select still low after data: a wide frame, eight more bits
        spi_chain_pkg::DEV_DATA: state_d = spi_chain_pkg::DEV_TAIL;
        spi_chain_pkg::DEV_TAIL: state_d = spi_chain_pkg::DEV_CTRL;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      state_q <= spi_chain_pkg::DEV_CTRL;
      bit_q <= 3'h0;
      shift_q <= 8'h00;
    end else begin
      state_q <= state_d;
      if (resync) begin
        bit_q <= 3'h0;
      end else if (take) begin
        bit_q <= bit_q + 3'h1;
        shift_q <= byte_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control byte capture and pass-through

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      bcast_q <= 1'b0;
      read_q <= 1'b0;
      target_q <= 1'b0;
      borrow_q <= 1'b1;
      fwd_q <= 1'b1;
      thru_q <= 1'b1;
    end else begin
      if (take && first_bit) begin
        bcast_q <= sdi_s;
      end
      if (take && in_ctrl) begin
        borrow_q <= borrow_d;
      end
      if (take) begin
        fwd_q <= fwd_bit;
      end
      if (drive) begin
        thru_q <= fwd_q;
      end
      if (byte_done && in_ctrl) begin
        read_q <= ctrl_read;
        target_q <= ctrl_target;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register access

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      addr_q <= '0;
      wdata_q <= 8'h00;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      rd_pend_q <= 1'b0;
    end else begin
      wr_q <= do_write;
      rd_q <= do_read;
      rd_pend_q <= rd_q;
      if (byte_done && (state_q == spi_chain_pkg::DEV_ADDR)) begin
        addr_q <= byte_in[spi_chain_pkg::ADDR_USED_W-1:0];
      end
      if (do_write) begin
        wdata_q <= byte_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data return

  // Rotating keeps the value for a repeat in the wide second half
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      out_q <= 8'h00;
      sdo_q <= 1'b1;
      oe_q <= 1'b0;
    end else begin
      if (rd_pend_q) begin
        out_q <= REG_RDATA_I;
      end else if (drive && answer && data_phase) begin
        out_q <= {out_q[6:0], out_q[7]};
      end
      if (drive && answer && data_phase) begin
        sdo_q <= out_q[7];
        oe_q <= 1'b1;
      end else if (!data_phase || !answer) begin
        oe_q <= 1'b0;
      end
    end
  end

  assign LINK.sdo = sdo_q;
  assign LINK.sdo_oe = oe_q;
  assign LINK.serial_pass_through_out = thru_q;
  assign REG_ADDR_O = addr_q;
  assign REG_WDATA_O = wdata_q;
  assign REG_WR_O = wr_q;
  assign REG_RD_O = rd_q;
  assign BCAST_O = bcast_q;

endmodule : spi_chain_device

// ===== hw/spi_chain_host.sv
// Serial controller end of the daisy-chain control port, APB driven
`timescale 1ns/1ps
module spi_chain_host #(
  parameter int HALF_CYC = spi_chain_pkg::SCLK_HALF_CYC
) (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  spi_chain_if.host LINK,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O
);

  ////////////////////////////////////////////////////////////////////////
  // Return line capture

  logic miso_s;

  spi_chain_sync #(
    .W(1)
  ) u_sync (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .d_i(LINK.miso),
    .lvl_o(miso_s),
    .rise_o(),
    .fall_o()
  );

  ////////////////////////////////////////////////////////////////////////
  // APB slave

  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic busy_q;
  logic [7:0] rdata_q;

  wire apb_acc = PSEL_I & PENABLE_I & ~pready_q;
  wire hit_cmd = (PADDR_I == spi_chain_pkg::OFF_CMD);
  wire hit_stat = (PADDR_I == spi_chain_pkg::OFF_STAT);
  wire start = apb_acc & PWRITE_I & hit_cmd & ~busy_q;
  wire [31:0] stat_word = {16'h0000, rdata_q, 7'h00, busy_q};

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= apb_acc;
      pslverr_q <= apb_acc & ~(hit_cmd | hit_stat);
      prdata_q <= (apb_acc && !PWRITE_I && hit_stat) ? stat_word : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command fields

  wire [3:0] cmd_cid = PWDATA_I[spi_chain_pkg::CMD_CID_LSB +: 4];
  wire cmd_bcast = PWDATA_I[spi_chain_pkg::CMD_BCAST_BIT];
  // Broadcast is sent as a write: a shared read would collide
  wire cmd_read = PWDATA_I[spi_chain_pkg::CMD_READ_BIT] & ~cmd_bcast;
  wire [5:0] cmd_addr = PWDATA_I[spi_chain_pkg::CMD_ADDR_LSB +: 6];
  wire [7:0] cmd_data = PWDATA_I[spi_chain_pkg::CMD_DATA_LSB +: 8];
  wire cmd_wide = PWDATA_I[spi_chain_pkg::CMD_WIDE_BIT];
  wire [7:0] ctrl_byte = {cmd_bcast, cmd_read, 1'b1, 1'b0,
                          cmd_cid[0], cmd_cid[1], cmd_cid[2],
                          cmd_cid[3]};
  wire [31:0] stream = {ctrl_byte, 2'b00, cmd_addr,
                        cmd_data, cmd_data};

  ////////////////////////////////////////////////////////////////////////
  // Frame generator

  spi_chain_pkg::host_state_t st_q;
  logic [15:0] div_q;
  logic [31:0] sh_q;
  logic [7:0] rx_q;
  logic [4:0] tot_q;
  logic [4:0] fbit_q;
  logic [1:0] frames_q;
  logic wide_q;
  logic rd_q;
  logic sclk_q;
  logic cs_n_q;
  logic mosi_q;
  logic mosi_oe_q;

  wire tick = (div_q == 16'(HALF_CYC - 1));
  wire [4:0] fbits = wide_q ? 5'(spi_chain_pkg::WORD_W) :
                              5'(spi_chain_pkg::BYTE_W);
  wire frame_end = (fbit_q == fbits);
  wire in_rd_data = rd_q & (tot_q >= spi_chain_pkg::DATA_BIT_IDX);

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I || st_q == spi_chain_pkg::H_IDLE || tick) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      st_q <= spi_chain_pkg::H_IDLE;
      busy_q <= 1'b0;
      rdata_q <= 8'h00;
      sh_q <= 32'h00000000;
      rx_q <= 8'h00;
      tot_q <= 5'h00;
      fbit_q <= 5'h00;
      frames_q <= 2'h0;
      wide_q <= 1'b0;
      rd_q <= 1'b0;
      sclk_q <= 1'b1;
      cs_n_q <= 1'b1;
      mosi_q <= 1'b1;
      mosi_oe_q <= 1'b1;
    end else begin
      unique case (st_q)
        spi_chain_pkg::H_IDLE: begin
          if (start) begin
            busy_q <= 1'b1;
            sh_q <= stream;
            wide_q <= cmd_wide;
            rd_q <= cmd_read;
            tot_q <= 5'h00;
            fbit_q <= 5'h00;
            frames_q <= cmd_wide ? spi_chain_pkg::FRAMES_WIDE :
                                   spi_chain_pkg::FRAMES_NARROW;
            cs_n_q <= 1'b0;
            st_q <= spi_chain_pkg::H_LEAD;
          end
        end
        spi_chain_pkg::H_LOW: begin
          if (tick) begin
            sclk_q <= 1'b1;
            rx_q <= {rx_q[6:0], miso_s};
            tot_q <= tot_q + 5'h01;
            fbit_q <= fbit_q + 5'h01;
            st_q <= spi_chain_pkg::H_HIGH;
          end
        end
        spi_chain_pkg::H_GAP: begin
          if (tick && frames_q == 2'h0) begin
            busy_q <= 1'b0;
            mosi_oe_q <= 1'b1;
            // Last eight bits hold the value in either framing
            if (rd_q) begin
              rdata_q <= rx_q;
            end
            st_q <= spi_chain_pkg::H_IDLE;
          end else if (tick) begin
            cs_n_q <= 1'b0;
            st_q <= spi_chain_pkg::H_LEAD;
          end
        end
        default: begin
          // Lead-in and high phase share the next-bit launch
          if (tick && st_q == spi_chain_pkg::H_HIGH && frame_end) begin
            cs_n_q <= 1'b1;
            fbit_q <= 5'h00;
            frames_q <= frames_q - 2'h1;
            st_q <= spi_chain_pkg::H_GAP;
          end else if (tick) begin
            sclk_q <= 1'b0;
            mosi_q <= sh_q[31];
            sh_q <= {sh_q[30:0], 1'b0};
            mosi_oe_q <= ~in_rd_data;
            st_q <= spi_chain_pkg::H_LOW;
          end
        end
      endcase
    end
  end

  assign LINK.sclk = sclk_q;
  assign LINK.cs_n = cs_n_q;
  assign LINK.mosi = mosi_q;
  assign LINK.mosi_oe = mosi_oe_q;
  assign PRDATA_O = prdata_q;
  assign PREADY_O = pready_q;
  assign PSLVERR_O = pslverr_q;

endmodule : spi_chain_host

// ===== tb/spi_chain_props.sv
// Link-level properties of the controller and device pair
`timescale 1ns/1ps
module spi_chain_props #(
  parameter int HALF_CYC = 15
) (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic mosi_oe,
  input wire logic sdo_oe,
  input wire logic miso
);
  logic [7:0] low_q;
  logic [5:0] rise_q;
  logic sclk_q;
  wire sclk_rise = sclk & ~sclk_q;
  always_ff @(posedge REF_CLK_I) begin
    sclk_q <= RST_I | sclk;
    low_q <= (RST_I | sclk) ? 8'h00 : low_q + 8'h01;
    rise_q <= (RST_I | cs_n) ? 6'h00 : rise_q + {5'h00, sclk_rise};
  end
  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  sequence s_high_run;
    sclk [*8];
  endsequence
  sequence s_low_run;
    !sclk [*8];
  endsequence
  reset_idle_a: assert property ($fell(RST_I) |-> cs_n && sclk && !sdo_oe)
    else $error("link not idle after reset");
  clock_idle_a: assert property (cs_n |-> sclk)
    else $error("serial clock not high outside a frame");
  select_lead_a: assert property ($fell(cs_n) |-> s_high_run)
    else $error("select fell too close to a clock fall");
  select_tail_a: assert property ($rose(cs_n) |-> $past(sclk, 8) && sclk)
    else $error("select rose too soon after last rise");
  half_period_a: assert property ($rose(sclk) |-> low_q == 8'(HALF_CYC))
    else $error("serial clock low phase has wrong length");
  low_phase_a: assert property ($fell(sclk) |=> s_low_run)
    else $error("serial clock low phase cut short");
  byte_count_a: assert property ($rose(cs_n) |-> rise_q == 6'h08 || rise_q == 6'h10)
    else $error("frame is not eight or sixteen clocks");
  drive_quiet_a: assert property (cs_n [*8] |-> !sdo_oe)
    else $error("device drives return line while deselected");
  oe_turn_a: assert property ($rose(sdo_oe) |-> !cs_n && !mosi_oe)
    else $error("return line driven against controller");
  return_idle_a: assert property (!sdo_oe |-> miso)
    else $error("released return line not high");
  mosi_steady_a: assert property (!cs_n && $stable(cs_n) && sclk && $stable(sclk)
      && mosi_oe && $stable(mosi_oe) |-> $stable(mosi))
    else $error("data line moved while clock high");
endmodule : spi_chain_props

// ===== tb/testbench.sv
// Self-checking bench: APB controller, a device, a bench-driven device
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [3:0] chain_channel_id;
    logic rd;
    logic bc;
    logic [5:0] addr;
    logic [7:0] wd;
    logic wide;
    logic exec;
  } row_t;
  row_t rows [8] = '{
    '{4'h0, 1'b0, 1'b0, 6'h3F, 8'hA5, 1'b0, 1'b1},
    '{4'h0, 1'b0, 1'b0, 6'h00, 8'h5A, 1'b1, 1'b1},
    '{4'h0, 1'b1, 1'b0, 6'h2A, 8'h00, 1'b0, 1'b1},
    '{4'h0, 1'b1, 1'b0, 6'h15, 8'h00, 1'b1, 1'b1},
    '{4'h3, 1'b0, 1'b0, 6'h11, 8'hC3, 1'b0, 1'b0},
    '{4'h5, 1'b1, 1'b0, 6'h22, 8'h00, 1'b0, 1'b0},
    '{4'h9, 1'b0, 1'b1, 6'h07, 8'h3C, 1'b0, 1'b1},
    '{4'hF, 1'b0, 1'b1, 6'h30, 8'h81, 1'b1, 1'b1}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, wr_a, rd_a, bc_a, wr_b, rd_b, bc_b, wr_bc, sclk_q;
  logic [5:0] addr_a, addr_b, wr_addr, wb_addr;
  logic [7:0] wd_a, wd_b, wr_data, wb_data;
  logic [31:0] mo_sh, pt_sh, mi_sh;
  int err_count = 0;
  int cmp_count = 0;
  int wr_cnt = 0;
  int rd_cnt = 0;
  int wb_cnt = 0;
  int nb = 0;
  wire [7:0] rdata_a = {2'h0, addr_a} ^ 8'hA5;
  spi_chain_if link_a ();
  spi_chain_if link_b ();
  spi_chain_host #(.HALF_CYC(15)) u_spi_chain_host (.REF_CLK_I(clk),
    .RST_I(rst), .LINK(link_a.host), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr));
  spi_chain_device u_spi_chain_device (.REF_CLK_I(clk), .RST_I(rst),
    .LINK(link_a.dev), .REG_ADDR_O(addr_a), .REG_WDATA_O(wd_a),
    .REG_WR_O(wr_a), .REG_RD_O(rd_a), .REG_RDATA_I(rdata_a), .BCAST_O(bc_a));
  spi_chain_device u_spi_chain_device_b (.REF_CLK_I(clk), .RST_I(rst),
    .LINK(link_b.dev), .REG_ADDR_O(addr_b), .REG_WDATA_O(wd_b),
    .REG_WR_O(wr_b), .REG_RD_O(rd_b), .REG_RDATA_I(8'h00), .BCAST_O(bc_b));
  spi_chain_props #(.HALF_CYC(15)) u_spi_chain_props (.REF_CLK_I(clk),
    .RST_I(rst), .sclk(link_a.sclk), .cs_n(link_a.cs_n),
    .mosi(link_a.mosi), .mosi_oe(link_a.mosi_oe), .sdo_oe(link_a.sdo_oe),
    .miso(link_a.miso));
  always #2 clk = ~clk;
  always @(posedge clk) begin
    sclk_q <= link_a.sclk;
    if (wr_a) begin
      wr_cnt++;
      wr_addr <= addr_a;
      wr_data <= wd_a;
      wr_bc <= bc_a;
    end
    if (rd_a) rd_cnt++;
    if (wr_b) begin
      wb_cnt++;
      wb_addr <= addr_b;
      wb_data <= wd_b;
    end
    // Bits taken at the controller's own sampling point
    if (!sclk_q && link_a.sclk && !link_a.cs_n) begin
      mo_sh <= {mo_sh[30:0], link_a.mosi};
      pt_sh <= {pt_sh[30:0], link_a.serial_pass_through_out};
      mi_sh <= {mi_sh[30:0], link_a.miso};
      nb++;
    end
  end
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input string w, input logic [31:0] x,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", w, x, g);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) err_count++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_idle();
    logic [31:0] q;
    logic e;
    int n;
    n = 0;
    do begin
      apb(1'b0, spi_chain_pkg::OFF_STAT, 32'h0, q, e);
      n++;
    end while (q[0] !== 1'b0 && n < 2000);
    chk("busy", 32'h0, {31'h0, q[0]});
  endtask : wait_idle
  task automatic run_row(input row_t r);
    logic [31:0] q;
    logic e;
    logic [7:0] ectl, epass, e8;
    logic [3:0] dec;
    int w0, r0;
    dec = r.chain_channel_id - 4'h1;
    ectl = {r.bc, r.rd, 2'b10, r.chain_channel_id[0], r.chain_channel_id[1], r.chain_channel_id[2], r.chain_channel_id[3]};
    epass = r.bc ? ectl : {r.bc, r.rd, 2'b10, dec[0], dec[1], dec[2], dec[3]};
    e8 = r.exec ? ({2'h0, r.addr} ^ 8'hA5) : 8'hFF;
    w0 = wr_cnt;
    r0 = rd_cnt;
    nb = 0;
    apb(1'b1, spi_chain_pkg::OFF_CMD, {7'h0, r.wide, r.wd, 2'h0, r.addr,
        2'h0, r.bc, r.rd, r.chain_channel_id}, q, e);
    wait_idle();
    chk("bits", r.wide ? 32'd32 : 32'd24, 32'(nb));
    chk("ctrl", {24'h0, ectl}, (mo_sh >> (nb - 8)) & 32'hFF);
    chk("addr", {26'h0, r.addr}, (mo_sh >> (nb - 16)) & 32'hFF);
    // Forwarded bit leaves on the fall after its rise: one bit late
    chk("fwd", {24'h0, epass}, (pt_sh >> (nb - 9)) & 32'hFF);
    chk("wr", {31'h0, r.exec & !r.rd}, 32'(wr_cnt - w0));
    chk("rd", {31'h0, r.exec & r.rd}, 32'(rd_cnt - r0));
    if (r.exec && !r.rd) begin
      chk("waddr", {26'h0, r.addr}, {26'h0, wr_addr});
      chk("wdata", {24'h0, r.wd}, {24'h0, wr_data});
      chk("bcast", {31'h0, r.bc}, {31'h0, wr_bc});
    end
    if (r.rd) begin
      apb(1'b0, spi_chain_pkg::OFF_STAT, 32'h0, q, e);
      chk("miso", r.wide ? {16'h0, e8, e8} : {24'h0, e8},
          mi_sh & (r.wide ? 32'hFFFF : 32'hFF));
      if (r.exec) chk("stat", {24'h0, e8}, {24'h0, q[15:8]});
    end
  endtask : run_row
  task automatic bb(input logic [7:0] v, input int n);
    link_b.cs_n <= 1'b0;
    repeat (16) @(posedge clk);
    for (int i = n - 1; i >= 0; i--) begin
      link_b.sclk <= 1'b0;
      link_b.mosi <= v[i];
      repeat (16) @(posedge clk);
      link_b.sclk <= 1'b1;
      repeat (16) @(posedge clk);
    end
    link_b.cs_n <= 1'b1;
    // Released line must not keep showing the last bit
    link_b.mosi <= ~v[0];
    repeat (32) @(posedge clk);
  endtask : bb
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] q;
    logic e;
    int w0;
    link_b.sclk = 1'b1;
    link_b.cs_n = 1'b1;
    link_b.mosi = 1'b1;
    link_b.mosi_oe = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    foreach (rows[i]) run_row(rows[i]);
    // Second command while busy must be dropped
    w0 = wr_cnt;
    apb(1'b1, spi_chain_pkg::OFF_CMD, 32'h00110100, q, e);
    apb(1'b1, spi_chain_pkg::OFF_CMD, 32'h00220200, q, e);
    wait_idle();
    chk("busy drop", 32'h1, 32'(wr_cnt - w0));
    chk("busy addr", 32'h01, {26'h0, wr_addr});
    apb(1'b0, 8'h08, 32'h0, q, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    apb(1'b1, spi_chain_pkg::OFF_STAT, 32'h1, q, e);
    chk("stat wr err", 32'h0, {31'h0, e});
    // Three stray bits, then a whole write must still land
    bb(8'h05, 3);
    bb(8'h20, 8);
    bb(8'h2B, 8);
    bb(8'h96, 8);
    chk("resync cnt", 32'h1, 32'(wb_cnt));
    chk("resync addr", 32'h2B, {26'h0, wb_addr});
    chk("resync data", 32'h96, {24'h0, wb_data});
    // Reset in mid-frame
    apb(1'b1, spi_chain_pkg::OFF_CMD, 32'h00330300, q, e);
    repeat (100) @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    chk("rst lines", 32'h3, {30'h0, link_a.cs_n, link_a.sclk});
    chk("rst oe", 32'h0, {30'h0, link_a.sdo_oe, pready});
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    run_row(rows[0]);
    conclude();
  end
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    conclude();
  end
endmodule : testbench
